// *** rtl/vfd_pkg.sv ***
// package: constants, types and encodings for the viewfinder display controller
`default_nettype none
package vfd_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_HZ            = 100_000_000;
	localparam int UPDATE_PERIOD_MS  = 600;
	localparam int BLINK_RATE_HZ     = 2;
	localparam int UPDATE_CYCLES     = CLK_HZ / 1000 * UPDATE_PERIOD_MS;
	localparam int BLINK_HALF_CYCLES = CLK_HZ / (2 * BLINK_RATE_HZ);

	// ------------------------------------------------------------
	// value codes, eighth steps
	// ------------------------------------------------------------
	localparam logic [7:0] TV_30S_CODE   = 8'h28;
	localparam logic [7:0] TV_1000_CODE  = 8'hA0;
	localparam logic [7:0] TV_60_CODE    = 8'h80;
	localparam logic [7:0] TV_STEP       = 8'h08;
	localparam logic [7:0] AV_56_CODE    = 8'h28;
	localparam logic [7:0] AV_16_CODE    = 8'h40;
	localparam logic [7:0] AV_19_CODE    = 8'h44;
	localparam logic [7:0] EV_LOW_CODE   = 8'h30;
	localparam logic [7:0] EV5_CODE      = 8'h68;
	localparam logic [7:0] EV11_CODE     = 8'h98;
	localparam logic [7:0] EV15_CODE     = 8'hB8;
	localparam logic [9:0] EV_TV_AV_OFS  = 10'h010;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0]  CTRL_ADDR    = 8'h00;
	localparam logic [7:0]  STATUS_ADDR  = 8'h04;
	localparam logic [7:0]  MASK_ADDR    = 8'h08;
	localparam logic [7:0]  SHOWN_ADDR   = 8'h0C;
	localparam logic        CTRL_RESET   = 1'b1;
	localparam int          EVT_W        = 3;
	localparam int          EVT_ERROR    = 0;
	localparam int          EVT_WARN     = 1;
	localparam int          EVT_UPDATE   = 2;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [2:0] {MODE_SHUTTER, MODE_APERTURE, MODE_PROGRAM, MODE_STOPDOWN} vfd_mode_t;
	typedef enum logic [1:0] {LVL_FULL, LVL_HALF, LVL_EIGHTH, LVL_SIXTEENTH} vfd_level_t;

	typedef struct packed {
		logic [7:0] calculated_shutter_speed;
		logic [7:0] calculated_aperture;
		logic [7:0] shutter_dial;
		logic [7:0] selected_aperture;
		logic [7:0] lens_max_aperture;
		logic [7:0] scene_ev;
		logic [7:0] finder_ev;
	} vfd_expo_t;

	typedef struct packed {
		logic flash_attached;
		logic flash_ready;
		logic flash_manual;
		logic dedicated_lens;
		logic lens_off_auto;
		logic stopped_down;
		logic stopdown_lever;
		logic bulb;
		logic ae_lock;
		logic self_timer;
		logic shutter_open;
		logic coupling_error;
	} vfd_cond_t;

	typedef struct packed {
		logic [6:0] tv_half;
		logic [6:0] av_half;
		logic       tv_on;
		logic       av_on;
		logic       tv_blink;
		logic       av_blink;
		logic       flash_glyph;
		logic       manual_glyph;
		logic       bulb_glyph;
		logic       coupling_error_pattern;
	} vfd_disp_t;

endpackage
`default_nettype wire

// *** rtl/vfd_top.sv ***
// viewfinder display controller with AHB-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module vfd_top #(
	parameter int UPDATE_CYCLES_P = vfd_pkg::UPDATE_CYCLES,
	parameter int BLINK_HALF_P    = vfd_pkg::BLINK_HALF_CYCLES
) (
	// clock and reset
	input  wire logic              CLK_IN,
	input  wire logic              SRST_IN,
	// ahb-lite slave
	input  wire logic              HSEL_IN,
	input  wire logic [31:0]       HADDR_IN,
	input  wire logic [1:0]        HTRANS_IN,
	input  wire logic              HWRITE_IN,
	input  wire logic [2:0]        HSIZE_IN,
	input  wire logic [31:0]       HWDATA_IN,
	input  wire logic              HREADY_IN,
	output logic [31:0]            HRDATA_OUT,
	output logic                   HREADYOUT_OUT,
	output logic                   HRESP_OUT,
	output logic                   IRQ_OUT,
	// exposure and camera state
	input  wire vfd_pkg::vfd_mode_t MODE_IN,
	input  wire vfd_pkg::vfd_expo_t EXPO_IN,
	input  wire vfd_pkg::vfd_cond_t COND_IN,
	// display drive
	output vfd_pkg::vfd_disp_t     DISP_OUT,
	output vfd_pkg::vfd_level_t    LEVEL_OUT,
	output logic                   LED_ON_OUT
);
	import vfd_pkg::*;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	function automatic logic [6:0] to_half(input logic [7:0] v);
		logic [8:0] t;
		t = {1'b0, v} + 9'h002;
		return t[8:2];
	endfunction

	function automatic logic [7:0] to_detent(input logic [7:0] v);
		logic [8:0] t;
		t = {1'b0, v} + 9'h004;
		if (t[8]) begin
			return 8'hF8;
		end
		return {t[7:3], 3'h0};
	endfunction

	// ------------------------------------------------------------
	// timers
	// ------------------------------------------------------------
	logic [31:0] upd_cnt;
	logic [31:0] blink_cnt;
	logic        upd_tick;
	logic        blink_phase;

	assign upd_tick = (upd_cnt == 32'(UPDATE_CYCLES_P - 1));

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN || upd_tick) begin
			upd_cnt <= 32'h0;
		end else begin
			upd_cnt <= upd_cnt + 32'h1;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			blink_cnt   <= 32'h0;
			blink_phase <= 1'b0;
		end else if (blink_cnt == 32'(BLINK_HALF_P - 1)) begin
			blink_cnt   <= 32'h0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 32'h1;
		end
	end

	// ------------------------------------------------------------
	// display content
	// ------------------------------------------------------------
	vfd_disp_t  next_disp;
	vfd_disp_t  shown;
	logic [7:0] av_eff;
	logic [7:0] tv_det;
	logic [7:0] av_clip;
	logic [9:0] tv_low;
	logic       low_light;
	logic       flash_ae;

	assign flash_ae  = COND_IN.flash_attached && COND_IN.flash_ready;
	assign low_light = EXPO_IN.scene_ev < EV_LOW_CODE;
	assign tv_low    = {2'b00, EV_LOW_CODE} - {2'b00, EXPO_IN.lens_max_aperture} + EV_TV_AV_OFS;

	always_comb begin
		next_disp = '0;
		av_eff = (EXPO_IN.selected_aperture < EXPO_IN.lens_max_aperture) ?
			EXPO_IN.lens_max_aperture : EXPO_IN.selected_aperture;
		tv_det = to_detent(EXPO_IN.shutter_dial);
		av_clip = (EXPO_IN.calculated_aperture < EXPO_IN.lens_max_aperture) ?
			EXPO_IN.lens_max_aperture : EXPO_IN.calculated_aperture;
		if (COND_IN.coupling_error) begin
			next_disp.coupling_error_pattern = 1'b1;
			next_disp.tv_blink = 1'b1;
			next_disp.av_blink = 1'b1;
		end else if (flash_ae) begin
			next_disp.flash_glyph = 1'b1;
			next_disp.bulb_glyph  = COND_IN.bulb;
			next_disp.tv_on       = ~COND_IN.bulb;
			next_disp.tv_half     = to_half(TV_60_CODE);
			next_disp.av_on       = ~COND_IN.flash_manual;
			if (COND_IN.dedicated_lens) begin
				next_disp.av_half  = to_half(av_eff);
				next_disp.av_blink = (EXPO_IN.selected_aperture < EXPO_IN.lens_max_aperture) ||
					(EXPO_IN.selected_aperture >= AV_19_CODE);
			end else begin
				next_disp.av_half  = to_half((EXPO_IN.selected_aperture < AV_56_CODE) ?
					AV_56_CODE : EXPO_IN.selected_aperture);
				next_disp.av_blink = (EXPO_IN.selected_aperture < AV_56_CODE) ||
					(EXPO_IN.selected_aperture >= AV_19_CODE);
			end
		end else if (COND_IN.bulb) begin
			next_disp.bulb_glyph = 1'b1;
		end else begin
			case (MODE_IN)
				MODE_SHUTTER: begin
					next_disp.tv_on    = 1'b1;
					next_disp.av_on    = 1'b1;
					next_disp.tv_half  = to_half(tv_det);
					next_disp.av_half  = to_half(av_clip);
					next_disp.av_blink = (EXPO_IN.calculated_aperture < EXPO_IN.lens_max_aperture) ||
						(EXPO_IN.calculated_aperture > AV_16_CODE);
					if (low_light) begin
						next_disp.tv_blink = 1'b1;
						next_disp.av_blink = 1'b1;
					end
				end
				MODE_APERTURE: begin
					next_disp.tv_on   = 1'b1;
					next_disp.av_on   = 1'b1;
					next_disp.av_half = to_half(av_eff);
					if (EXPO_IN.calculated_shutter_speed <= TV_30S_CODE) begin
						next_disp.tv_half  = to_half(TV_30S_CODE);
						next_disp.tv_blink = 1'b1;
					end else if (EXPO_IN.calculated_shutter_speed >= TV_1000_CODE) begin
						next_disp.tv_half  = to_half(TV_1000_CODE);
						next_disp.tv_blink = 1'b1;
					end else begin
						next_disp.tv_half = to_half(EXPO_IN.calculated_shutter_speed);
					end
					if (low_light) begin
						next_disp.tv_blink = 1'b1;
						next_disp.av_blink = 1'b1;
					end
				end
				MODE_PROGRAM: begin
					next_disp.tv_on = 1'b1;
					next_disp.av_on = 1'b1;
					if (EXPO_IN.calculated_aperture >= AV_16_CODE &&
						EXPO_IN.calculated_shutter_speed >= TV_1000_CODE) begin
						next_disp.tv_half  = to_half(TV_1000_CODE);
						next_disp.av_half  = to_half(EXPO_IN.calculated_aperture);
						next_disp.tv_blink = 1'b1;
						next_disp.av_blink = 1'b1;
					end else if (tv_low[9] == 1'b0 &&
						{2'b00, EXPO_IN.calculated_shutter_speed} < tv_low) begin
						next_disp.av_half  = to_half(EXPO_IN.lens_max_aperture);
						next_disp.tv_half  = (tv_low[7:0] > TV_STEP) ? to_half(tv_low[7:0] - TV_STEP) : 7'h00;
						next_disp.tv_blink = 1'b1;
						next_disp.av_blink = 1'b1;
					end else begin
						next_disp.tv_half = to_half(EXPO_IN.calculated_shutter_speed);
						next_disp.av_half = to_half(av_clip);
					end
				end
				MODE_STOPDOWN: begin
					next_disp.tv_on    = 1'b1;
					next_disp.tv_half  = to_half(EXPO_IN.calculated_shutter_speed);
					next_disp.tv_blink = low_light;
				end
				default: begin
					next_disp.tv_on = 1'b0;
				end
			endcase
		end
		if (COND_IN.flash_attached) begin
			next_disp.manual_glyph = COND_IN.lens_off_auto || COND_IN.flash_manual ||
				COND_IN.stopdown_lever ||
				(COND_IN.bulb && (COND_IN.lens_off_auto || COND_IN.flash_manual));
		end else begin
			next_disp.manual_glyph = (COND_IN.lens_off_auto && !COND_IN.stopped_down) ||
				COND_IN.bulb;
		end
		if (COND_IN.coupling_error) begin
			next_disp.manual_glyph = 1'b0;
		end
	end

	// values held between refreshes
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			shown <= '0;
		end else if (upd_tick) begin
			shown <= next_disp;
		end
	end

	// ------------------------------------------------------------
	// register file and ahb-lite slave
	// ------------------------------------------------------------
	logic                 ctrl_on;
	logic [EVT_W-1:0]     status;
	logic [EVT_W-1:0]     mask;
	logic [EVT_W-1:0]     evt;
	logic                 wr_pend;
	logic [7:0]           wr_addr;
	logic                 acc;
	logic                 err_seen;

	assign acc           = HSEL_IN && HTRANS_IN[1] && HREADY_IN;
	assign HREADYOUT_OUT = 1'b1;
	assign HRESP_OUT     = 1'b0;
	assign IRQ_OUT       = |(status & mask);

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			err_seen <= 1'b0;
		end else begin
			err_seen <= shown.coupling_error_pattern;
		end
	end

	always_comb begin
		evt = '0;
		evt[EVT_ERROR]  = shown.coupling_error_pattern && !err_seen;
		evt[EVT_WARN]   = upd_tick && (next_disp.tv_blink || next_disp.av_blink) &&
			!(shown.tv_blink || shown.av_blink);
		evt[EVT_UPDATE] = upd_tick;
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= acc && HWRITE_IN;
			wr_addr <= HADDR_IN[7:0];
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			ctrl_on <= CTRL_RESET;
			mask    <= '0;
		end else if (wr_pend) begin
			if (wr_addr == CTRL_ADDR) begin
				ctrl_on <= HWDATA_IN[0];
			end
			if (wr_addr == MASK_ADDR) begin
				mask <= HWDATA_IN[EVT_W-1:0];
			end
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			status <= '0;
		end else if (wr_pend && wr_addr == STATUS_ADDR) begin
			status <= (status & ~HWDATA_IN[EVT_W-1:0]) | evt;
		end else begin
			status <= status | evt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			HRDATA_OUT <= 32'h0;
		end else if (acc && !HWRITE_IN) begin
			case (HADDR_IN[7:0])
				CTRL_ADDR:   HRDATA_OUT <= {31'h0, ctrl_on};
				STATUS_ADDR: HRDATA_OUT <= {29'h0, status};
				MASK_ADDR:   HRDATA_OUT <= {29'h0, mask};
				SHOWN_ADDR:  HRDATA_OUT <= {8'h0, LEVEL_OUT, shown};
				default:     HRDATA_OUT <= 32'h0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// brightness
	// ------------------------------------------------------------
	vfd_level_t next_level;
	logic       lock_d;
	logic [3:0] pwm_cnt;
	logic [4:0] duty;

	always_comb begin
		if (EXPO_IN.finder_ev > EV15_CODE) begin
			next_level = LVL_FULL;
		end else if (EXPO_IN.finder_ev >= EV11_CODE) begin
			next_level = LVL_HALF;
		end else if (EXPO_IN.finder_ev >= EV5_CODE) begin
			next_level = LVL_EIGHTH;
		end else begin
			next_level = LVL_SIXTEENTH;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			LEVEL_OUT <= LVL_FULL;
			lock_d    <= 1'b0;
		end else begin
			lock_d <= COND_IN.ae_lock;
			if (flash_ae) begin
				LEVEL_OUT <= LVL_EIGHTH;
			end else if (!(COND_IN.ae_lock && lock_d)) begin
				LEVEL_OUT <= next_level;
			end
		end
	end

	always_comb begin
		case (LEVEL_OUT)
			LVL_FULL:   duty = 5'h10;
			LVL_HALF:   duty = 5'h08;
			LVL_EIGHTH: duty = 5'h02;
			default:    duty = 5'h01;
		endcase
	end

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			pwm_cnt    <= 4'h0;
			LED_ON_OUT <= 1'b0;
		end else begin
			pwm_cnt    <= pwm_cnt + 4'h1;
			LED_ON_OUT <= {1'b0, pwm_cnt} < duty;
		end
	end

	// ------------------------------------------------------------
	// segment drive
	// ------------------------------------------------------------
	logic blank;

	assign blank = COND_IN.self_timer || COND_IN.shutter_open || !ctrl_on;

	always_ff @(posedge CLK_IN) begin
		if (SRST_IN) begin
			DISP_OUT <= '0;
		end else begin
			DISP_OUT          <= shown;
			DISP_OUT.tv_on    <= !blank && shown.tv_on && !(shown.tv_blink && blink_phase);
			DISP_OUT.av_on    <= !blank && shown.av_on && !(shown.av_blink && blink_phase);
			DISP_OUT.flash_glyph  <= !blank && shown.flash_glyph;
			DISP_OUT.manual_glyph <= !blank && shown.manual_glyph;
			DISP_OUT.bulb_glyph   <= !blank && shown.bulb_glyph;
			DISP_OUT.coupling_error_pattern <= !blank && shown.coupling_error_pattern && !blink_phase;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge CLK_IN); endclocking
	default disable iff (SRST_IN);

	property p_blink;
		(blink_cnt == 32'(BLINK_HALF_P - 1)) |=> (blink_phase != $past(blink_phase)) && (blink_cnt == 32'h0);
	endproperty
	a_blink: assert property (p_blink) else $error("blink phase did not toggle");

	property p_hold;
		!upd_tick |=> $stable(shown);
	endproperty
	a_hold: assert property (p_hold) else $error("display changed between refreshes");

	property p_blank;
		(COND_IN.self_timer || COND_IN.shutter_open) |=> !DISP_OUT.tv_on && !DISP_OUT.av_on && !DISP_OUT.flash_glyph;
	endproperty
	a_blank: assert property (p_blank) else $error("display not blanked");

	property p_error;
		upd_tick && COND_IN.coupling_error |=> shown.coupling_error_pattern && shown.tv_blink && shown.av_blink;
	endproperty
	a_error: assert property (p_error) else $error("error pattern missing");

	property p_flash_lvl;
		flash_ae |=> LEVEL_OUT == LVL_EIGHTH;
	endproperty
	a_flash_lvl: assert property (p_flash_lvl) else $error("flash level not one eighth");

	property p_lock;
		COND_IN.ae_lock && lock_d && !flash_ae |=> $stable(LEVEL_OUT);
	endproperty
	a_lock: assert property (p_lock) else $error("locked level changed");

	property p_bright;
		!COND_IN.ae_lock && !flash_ae && EXPO_IN.finder_ev > EV15_CODE |=> LEVEL_OUT == LVL_FULL;
	endproperty
	a_bright: assert property (p_bright) else $error("full brightness not chosen");

	property p_manual;
		upd_tick && !COND_IN.flash_attached && COND_IN.bulb && !COND_IN.coupling_error |=> shown.manual_glyph;
	endproperty
	a_manual: assert property (p_manual) else $error("manual letter missing on bulb");

	property p_stopdown;
		upd_tick && MODE_IN == MODE_STOPDOWN && !flash_ae && !COND_IN.bulb && !COND_IN.coupling_error &&
			low_light |=> shown.tv_blink && !shown.av_on;
	endproperty
	a_stopdown: assert property (p_stopdown) else $error("stopped-down warning wrong");

	property p_av_limit;
		upd_tick && MODE_IN == MODE_APERTURE && !flash_ae && !COND_IN.bulb && !COND_IN.coupling_error &&
			EXPO_IN.calculated_shutter_speed >= TV_1000_CODE |=> shown.tv_blink &&
			shown.tv_half == to_half(TV_1000_CODE);
	endproperty
	a_av_limit: assert property (p_av_limit) else $error("shutter limit not flashed");

endmodule
`default_nettype wire

// *** tb/vfd_expo_src.sv ***
// partner model: exposure computation side feeding the display controller
`timescale 1ns/1ps
`default_nettype none
module vfd_expo_src (
	// clock
	input  wire logic              clk_in,
	// requested exposure results
	input  wire vfd_pkg::vfd_mode_t mode_in,
	input  wire vfd_pkg::vfd_expo_t expo_in,
	input  wire vfd_pkg::vfd_cond_t cond_in,
	// presented to the controller
	output var vfd_pkg::vfd_mode_t  mode_out,
	output var vfd_pkg::vfd_expo_t  expo_out,
	output var vfd_pkg::vfd_cond_t  cond_out
);
	import vfd_pkg::*;
	// ------------------------------------------------------------
	// results presented one cycle after computation
	// ------------------------------------------------------------
	always_ff @(posedge clk_in) begin
		mode_out <= mode_in;
		expo_out <= expo_in;
		cond_out <= cond_in;
	end
endmodule
`default_nettype wire

// *** tb/viewfinder_display_control_tb.sv ***
// testbench: display controller against a behavioural model
`timescale 1ns/1ps
`default_nettype none
module viewfinder_display_control_tb;
	import vfd_pkg::*;
	localparam int UPD = 20;
	localparam int BLK = 4;
	logic        clk    = 1'b0;
	logic        srst   = 1'b1;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hready;
	logic        irq;
	logic        led;
	logic        hresp;
	vfd_mode_t   mode_r = MODE_SHUTTER;
	vfd_expo_t   expo_r = '0;
	vfd_cond_t   cond_r = '0;
	vfd_mode_t   mode_w;
	vfd_expo_t   expo_w;
	vfd_cond_t   cond_w;
	vfd_disp_t   disp;
	vfd_level_t  level;
	int          fail_count = 0;
	int          num_checks = 0;
	int          n_tv;
	int          n_err;
	int          n_ph;
	int          code;
	int          n_led;
	int          duty_tab[4] = '{16, 8, 2, 1};
	logic [31:0] rd;
	int          evs[4]  = '{'hC0, 'hA8, 'h80, 'h40};
	logic [11:0] mcond[7] = '{12'h080, 12'h0C0, 12'h010, 12'hE00, 12'hD00, 12'hD20, 12'hD10};
	logic        mexp[7]  = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};

	always #5 clk = ~clk;

	vfd_expo_src partner (.clk_in(clk), .mode_in(mode_r), .expo_in(expo_r), .cond_in(cond_r),
		.mode_out(mode_w), .expo_out(expo_w), .cond_out(cond_w));

	vfd_top #(.UPDATE_CYCLES_P(UPD), .BLINK_HALF_P(BLK)) dut (.CLK_IN(clk), .SRST_IN(srst), .HSEL_IN(hsel),
		.HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2), .HWDATA_IN(hwdata),
		.HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready), .HRESP_OUT(hresp), .IRQ_OUT(irq),
		.MODE_IN(mode_w), .EXPO_IN(expo_w), .COND_IN(cond_w), .DISP_OUT(disp), .LEVEL_OUT(level),
		.LED_ON_OUT(led));

	// ------------------------------------------------------------
	// reporting
	// ------------------------------------------------------------
	task final_report;
		begin
			$display("checks %0d mismatches %0d", num_checks, fail_count);
			if (fail_count == 0 && num_checks > 0) begin
				$display("== PASSED ==");
			end else begin
				$display("== FAILED ==");
			end
			$finish;
		end
	endtask

	task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		begin
			num_checks++;
			if (got !== exp) begin
				fail_count++;
				$display("[ERR] %s expected %h seen %h", nm, exp, got);
			end
		end
	endtask

	task tend(input string nm);
		$display("test %s done", nm);
	endtask

	// ------------------------------------------------------------
	// bus master and waits
	// ------------------------------------------------------------
	task wait_rdy;
		int n;
		begin
			n = 0;
			do begin
				@(posedge clk);
				n++;
			end while (hready !== 1'b1 && n < 50);
			if (hready !== 1'b1) begin
				chk("bus wait", 32'h1, 32'h0);
				final_report;
			end
		end
	endtask

	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		begin
			hsel <= 1'b1;
			haddr <= {24'h0, a};
			htrans <= 2'h2;
			hwrite <= w;
			wait_rdy;
			htrans <= 2'h0;
			hwdata <= wd;
			wait_rdy;
			rd = hrdata;
			chk("resp", 32'h0, hresp);
		end
	endtask

	task wait_ref;
		repeat (2 * UPD + 5) @(posedge clk);
	endtask

	task sample16;
		begin
			n_tv = 0;
			n_err = 0;
			n_ph = 0;
			n_led = 0;
			repeat (16) begin
				@(posedge clk);
				n_tv += int'(disp.tv_on);
				n_led += int'(led);
				n_err += int'(disp.coupling_error_pattern);
				n_ph += int'(disp.tv_on !== disp.av_on);
			end
		end
	endtask

	// ------------------------------------------------------------
	// behavioural model
	// ------------------------------------------------------------
	function automatic int lvl_of(input int ev);
		if (ev > 'hB8) return 0;
		if (ev >= 'h98) return 1;
		if (ev >= 'h68) return 2;
		return 3;
	endfunction

	function automatic int half_of(input int c);
		return (c + 2) / 4;
	endfunction

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h4B24));
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		@(posedge clk);
		ahb(1'b0, CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h1, rd);
		ahb(1'b0, MASK_ADDR, 32'h0);
		chk("mask", 32'h0, rd);
		ahb(1'b0, 8'h10, 32'h0);
		chk("unmapped", 32'h0, rd);
		tend("reset");
		foreach (evs[i]) begin
			expo_r.finder_ev <= evs[i][7:0];
			repeat (3) @(posedge clk);
			chk("level", lvl_of(evs[i]), level);
			sample16;
			chk("led duty", duty_tab[lvl_of(evs[i])], n_led);
		end
		expo_r.finder_ev <= 8'hC0;
		cond_r <= 12'hC00;
		repeat (3) @(posedge clk);
		chk("flash level", 32'h2, level);
		sample16;
		chk("flash duty", 32'd2, n_led);
		cond_r <= 12'h008;
		expo_r.finder_ev <= 8'h40;
		repeat (3) @(posedge clk);
		expo_r.finder_ev <= 8'hC0;
		repeat (3) @(posedge clk);
		chk("held level", 32'h3, level);
		cond_r <= 12'h000;
		repeat (3) @(posedge clk);
		chk("free level", 32'h0, level);
		tend("brightness");
		mode_r <= MODE_APERTURE;
		expo_r.scene_ev <= 8'h80;
		expo_r.selected_aperture <= 8'h18;
		expo_r.lens_max_aperture <= 8'h20;
		for (int i = 0; i < 5; i++) begin
			code = (i == 0) ? 'h28 : (i == 1) ? 'hA0 : 'h30 + $urandom % 'h68;
			expo_r.calculated_shutter_speed <= code[7:0];
			wait_ref;
			chk("tv half", half_of(code), disp.tv_half);
			chk("tv blink", i < 2, disp.tv_blink);
			chk("av half", half_of('h20), disp.av_half);
		end
		expo_r.scene_ev <= 8'h20;
		wait_ref;
		chk("low blink", 32'h3, {disp.tv_blink, disp.av_blink});
		sample16;
		chk("duty", 32'd8, n_tv);
		chk("phase", 32'd0, n_ph);
		cond_r <= 12'h004;
		repeat (3) @(posedge clk);
		sample16;
		chk("blank", 32'd0, n_tv);
		cond_r <= 12'h000;
		tend("aperture priority");
		@(posedge clk);
		mode_r <= MODE_SHUTTER;
		expo_r.scene_ev <= 8'h80;
		expo_r.shutter_dial <= 8'h6B;
		wait_ref;
		chk("detent", half_of('h68), disp.tv_half);
		mode_r <= MODE_STOPDOWN;
		expo_r.calculated_shutter_speed <= 8'h50;
		expo_r.scene_ev <= 8'h20;
		wait_ref;
		sample16;
		chk("stopdown blink", 32'h1, disp.tv_blink);
		chk("stopdown av", 32'd8, n_ph);
		expo_r.scene_ev <= 8'h80;
		cond_r <= 12'hC00;
		expo_r.selected_aperture <= 8'h30;
		wait_ref;
		chk("flash tv", half_of('h80), disp.tv_half);
		chk("flash glyph", 32'h1, disp.flash_glyph);
		chk("flash av", half_of('h30), disp.av_half);
		expo_r.selected_aperture <= 8'h20;
		wait_ref;
		chk("flash floor", half_of('h28), disp.av_half);
		chk("flash warn", 32'h1, disp.av_blink);
		tend("modes");
		foreach (mcond[i]) begin
			cond_r <= mcond[i];
			wait_ref;
			chk("manual", mexp[i], disp.manual_glyph);
			chk("bulb glyph", mcond[i][4], disp.bulb_glyph);
		end
		cond_r <= 12'h000;
		tend("manual letter");
		mode_r <= MODE_APERTURE;
		expo_r.calculated_shutter_speed <= 8'h60;
		wait_ref;
		expo_r.calculated_shutter_speed <= 8'h80;
		n_tv = 0;
		while (disp.tv_half === 7'(half_of('h60)) && n_tv < UPD + 5) begin
			@(posedge clk);
			n_tv++;
		end
		expo_r.calculated_shutter_speed <= 8'h40;
		n_tv = 0;
		while (disp.tv_half === 7'(half_of('h80)) && n_tv < UPD + 5) begin
			@(posedge clk);
			n_tv++;
		end
		chk("refresh gap", 32'h1, n_tv >= UPD - 3 && n_tv <= UPD + 2);
		tend("refresh");
		mode_r <= MODE_PROGRAM;
		expo_r.lens_max_aperture <= 8'h08;
		expo_r.calculated_aperture <= 8'h40;
		expo_r.calculated_shutter_speed <= 8'hA8;
		wait_ref;
		chk("prog high", {7'(half_of('hA0)), 7'(half_of('h40)), 2'b11},
			{disp.tv_half, disp.av_half, disp.tv_blink, disp.av_blink});
		expo_r.calculated_aperture <= 8'h08;
		expo_r.calculated_shutter_speed <= 8'h20;
		wait_ref;
		// low limit: ev -2 code minus lens maximum plus the tv offset, one stop down
		chk("prog low", {7'(half_of('h30 - 'h08 + 'h10 - 'h08)), 7'(half_of('h08)), 2'b11},
			{disp.tv_half, disp.av_half, disp.tv_blink, disp.av_blink});
		tend("programmed");
		cond_r <= 12'h001;
		wait_ref;
		sample16;
		chk("error flash", 32'd8, n_err);
		ahb(1'b0, STATUS_ADDR, 32'h0);
		chk("error status", 32'h1, rd[EVT_ERROR]);
		ahb(1'b1, MASK_ADDR, 32'h1);
		@(posedge clk);
		chk("irq set", 32'h1, irq);
		cond_r <= 12'h000;
		repeat (3) @(posedge clk);
		ahb(1'b1, STATUS_ADDR, 32'h1);
		@(posedge clk);
		chk("irq clear", 32'h0, irq);
		tend("error and interrupt");
		final_report;
	end
endmodule
`default_nettype wire
